// ===== hdl/smf_pkg.sv
// constants and types shared by the mode-fault and pin-control block
package smf_pkg;

	////////////////////////////////////////////////////////////////////////
	// register word addresses on the avalon slave
	localparam int ADR_W = 3;
	localparam logic [2:0] ADR_CTRL = 3'h0;
	localparam logic [2:0] ADR_STAT = 3'h1;
	localparam logic [2:0] ADR_MASK = 3'h2;
	localparam logic [2:0] ADR_DATA = 3'h3;
	localparam logic [2:0] ADR_PDIR = 3'h4;
	localparam logic [2:0] ADR_PDAT = 3'h5;

	////////////////////////////////////////////////////////////////////////
	// control register fields
	localparam int CB_EN = 0;
	localparam int CB_MSTR = 1;
	localparam int CB_CLOCK_PHASE = 2;
	localparam int CB_CPOL = 3;
	localparam int CB_FDEN = 4;
	localparam int CB_ERROR_INTERRUPT_ENABLE = 5;

	// status and mask fields
	localparam int SB_RXF = 0;
	localparam int SB_OVR = 1;
	localparam int SB_MODE_FAULT_FLAG = 2;
	localparam int SB_TXE = 3;

	// pin positions in port direction and port data
	localparam int PB_SCK = 0;
	localparam int PB_MOSI = 1;
	localparam int PB_MISO = 2;
	localparam int PB_SEL = 3;

	////////////////////////////////////////////////////////////////////////
	// values after reset
	localparam logic [5:0] CTRL_RST = 6'h00;
	localparam logic [3:0] STAT_RST = 4'h8;
	localparam logic [3:0] MASK_RST = 4'h0;
	localparam logic [3:0] PDIR_RST = 4'h0;
	localparam logic [3:0] PDAT_RST = 4'h0;
	localparam logic [7:0] BYTE_RST = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// bit counts and master clock timing
	localparam int BYTE_W = 8;
	localparam int CNT_W = 4;
	localparam logic [3:0] CNT_LAST = 4'h7;
	localparam logic [3:0] CNT_FULL = 4'h8;
	localparam int SYS_CLK_MHZ = 10;
	localparam int LINK_HALF_NS = 400;
	localparam int HALF_RAW = (LINK_HALF_NS * SYS_CLK_MHZ) / 1000;
	localparam int HALF_CYC = (HALF_RAW < 1) ? 1 : HALF_RAW;

	// transfer state
	typedef enum logic [1:0] {X_IDLE, X_MASTER, X_SLAVE} smf_xfer_t;

endpackage : smf_pkg

// ===== hdl/smf_shift_if.sv
// carrier between the control logic and the byte shifter
`timescale 1ns/1ns
interface smf_shift_if;
	logic clr;
	logic load;
	logic sample;
	logic shift;
	logic bit_in;
	logic bit_out;
	logic [7:0] load_data;
	logic [7:0] data;
	logic [3:0] cnt;
	modport ctl (output clr, load, sample, shift, bit_in, load_data,
		input bit_out, data, cnt);
	modport sh (input clr, load, sample, shift, bit_in, load_data,
		output bit_out, data, cnt);
endinterface : smf_shift_if

// ===== hdl/smf_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module smf_sync #(
	parameter int W = 1
) (
	input wire logic sys_clk, // system clock
	input wire logic rst_n, // async reset, active low
	input wire logic clk_en, // freezes state while low
	input wire logic [W-1:0] d, // asynchronous levels
	output logic [W-1:0] q // synchronised levels
);
	logic [W-1:0] meta_r;
	logic [W-1:0] q_r;

	// first stage feeds only the second
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			q_r <= '0;
		end else if (clk_en) begin
			meta_r <= d;
			q_r <= meta_r;
		end
	end

	assign q = q_r;
endmodule : smf_sync

// ===== hdl/smf_shift.sv
// byte shifter with held sample bit and sample counter
`timescale 1ns/1ns
module smf_shift (
	input wire logic sys_clk, // system clock
	input wire logic rst_n, // async reset, active low
	input wire logic clk_en, // freezes state while low
	smf_shift_if.sh bus // control and data
);
	import smf_pkg::*;

	logic [7:0] sreg_r;
	logic held_r;
	logic [3:0] cnt_r;

	// sample captures a bit, shift moves it in and presents the next
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sreg_r <= BYTE_RST;
			held_r <= 1'b0;
			cnt_r <= '0;
		end else if (clk_en) begin
			if (bus.clr) begin
				sreg_r <= BYTE_RST;
				cnt_r <= '0;
			end else if (bus.load) begin
				sreg_r <= bus.load_data;
				cnt_r <= '0;
			end else begin
				if (bus.sample) begin
					held_r <= bus.bit_in;
					cnt_r <= cnt_r + 4'h1;
				end
				if (bus.shift) begin
					sreg_r <= {sreg_r[6:0],
						bus.sample ? bus.bit_in : held_r};
				end
			end
		end
	end

	assign bus.bit_out = sreg_r[7];
	assign bus.data = sreg_r;
	assign bus.cnt = cnt_r;
endmodule : smf_shift

// ===== hdl/smf_top.sv
// serial peripheral mode-fault detection, framing and pin control
//
// Summary of operation
// RL1 - master drives clock and master-out, slave drives master-in
// RL2 - fault: slave select rises mid-transfer, or master select goes low
// RL3 - fault flag sets only with detect enable; disabling keeps set flag
// RL4 - fault with error enable raises the shared receive/error interrupt
// RL5 - master fault: disable, set transmit-empty, clear counter, port pins
// RL6 - software clears port directions before re-enabling after a fault
// RL7 - phase 0 slave: start on select fall, end idle after bit eight
// RL8 - phase 1 slave: start when clock leaves idle with select low
// RL9 - fault keeps master-select bit; that bit idle while disabled
// RL10 - phase 0 select then deselect faults; phase 1 does not
// RL11 - phase 0 slave drives top data bit once select goes low
// RL12 - enabled block owns clock and master-out direction
// RL13 - one byte is exchanged per eight serial clock cycles
// RL14 - phase 0 master toggles select between bytes; phase 1 may not
// RL15 - slave select is always input; detect enable still gates faults
// RL16 - deselected slave floats master-in and ignores clock edges
// RL17 - master select is port pin without detect, input with it
// RL18 - select pin level readable through port data when input
// RL19 - select and clock inputs synchronised before use
//
// Design decisions made here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ns
module smf_top #(
	parameter int HALF = smf_pkg::HALF_CYC // master clock half period
) (
	input wire logic sys_clk, // system clock
	input wire logic rst_n, // async reset, active low
	input wire logic clk_en, // freezes all state while low
	input wire logic [smf_pkg::ADR_W-1:0] avs_address, // word address
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic [31:0] avs_writedata, // write data
	input wire logic [3:0] avs_byteenable, // byte lanes
	output logic [31:0] avs_readdata, // read data
	output logic avs_waitrequest, // stall
	output logic irq, // level interrupt
	input wire logic serial_clock_pin, // clock pin level
	output logic serial_clock_drv, // clock pin drive value
	output logic serial_clock_oe, // clock pin drive enable
	input wire logic mosi_pin, // master-out pin level
	output logic mosi_drv, // master-out drive value
	output logic mosi_oe, // master-out drive enable
	input wire logic miso_pin, // master-in pin level
	output logic miso_drv, // master-in drive value
	output logic miso_oe, // master-in drive enable
	input wire logic select_pin, // select pin level, active low
	output logic select_drv, // select drive value
	output logic select_oe // select drive enable
);
	import smf_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// declarations
	logic [5:0] ctrl_r;
	logic [3:0] stat_r;
	logic [3:0] mask_r;
	logic [3:0] pdir_r;
	logic [3:0] pdat_r;
	logic [7:0] tx_r;
	logic [7:0] rx_r;
	logic [31:0] rdata_r;
	logic ack_r;
	smf_xfer_t xs_r;
	logic [7:0] div_r;
	logic sck_gen_r;
	logic sck_q_r;
	logic ss_q_r;
	logic done_r;
	logic [3:0] pin_s;
	logic [3:0] oe_nxt;
	logic [3:0] drv_nxt;
	logic [3:0] oe_r;
	logic [3:0] drv_r;
	logic [7:0] rd_mux;
	logic [3:0] stat_set;
	logic [3:0] stat_clr;
	logic en, mstr, clock_phase, cpol, fden, error_interrupt_enable;
	logic sck_s, mosi_s, miso_s, ss_s;
	logic req, acc, rd_stat, wr_ok;
	logic slave_on, ss_fall, s_edge, s_lead, s_trail;
	logic m_tick, m_lead, m_trail;
	logic m_start, s_start0, s_start1, s_abort;
	logic lead_e, trail_e, done;
	logic mf_master, mf_slave;

	smf_shift_if sif();

	////////////////////////////////////////////////////////////////////////
	// control fields
	assign en = ctrl_r[CB_EN];
	assign mstr = ctrl_r[CB_MSTR];
	assign clock_phase = ctrl_r[CB_CLOCK_PHASE];
	assign cpol = ctrl_r[CB_CPOL];
	assign fden = ctrl_r[CB_FDEN];
	assign error_interrupt_enable = ctrl_r[CB_ERROR_INTERRUPT_ENABLE];

	// pin inputs pass two flops; select enters inverted so reset reads idle
	smf_sync #(.W(4)) u_sync (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.d({~select_pin, miso_pin, mosi_pin, serial_clock_pin}),
		.q(pin_s)
	); // RL19

	assign sck_s = pin_s[PB_SCK];
	assign mosi_s = pin_s[PB_MOSI];
	assign miso_s = pin_s[PB_MISO];
	assign ss_s = ~pin_s[PB_SEL];

	// byte shifter
	smf_shift u_shift (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.bus(sif.sh)
	);

	////////////////////////////////////////////////////////////////////////
	// avalon slave: one wait state, registered read data
	assign req = avs_read | avs_write;
	assign acc = req & ack_r & clk_en;
	assign avs_waitrequest = req & ~(ack_r & clk_en);
	assign wr_ok = acc & avs_write & avs_byteenable[0];
	assign rd_stat = acc & avs_read & (avs_address == ADR_STAT);
	assign avs_readdata = rdata_r;

	// wait-state toggle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_r <= 1'b0;
		end else if (clk_en) begin
			ack_r <= req & ~ack_r;
		end
	end

	// read mux, unmapped addresses read zero
	always_comb begin
		rd_mux = 8'h00;
		if (avs_address == ADR_CTRL) begin
			rd_mux = {2'h0, ctrl_r};
		end else if (avs_address == ADR_STAT) begin
			rd_mux = {4'h0, stat_r};
		end else if (avs_address == ADR_MASK) begin
			rd_mux = {4'h0, mask_r};
		end else if (avs_address == ADR_DATA) begin
			rd_mux = rx_r;
		end else if (avs_address == ADR_PDIR) begin
			rd_mux = {4'h0, pdir_r};
		end else if (avs_address == ADR_PDAT) begin
			rd_mux = {4'h0, (oe_r & pdat_r) |
				(~oe_r & (pin_s ^ (4'h1 << PB_SEL)))}; // RL18
		end
	end

	// capture read data in the wait cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= 32'h0000_0000;
		end else if (clk_en && avs_read && !ack_r) begin
			rdata_r <= {24'h00_0000, rd_mux};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// edge detection and transfer framing
	assign slave_on = en & ~mstr;
	assign ss_fall = ss_q_r & ~ss_s;
	assign s_edge = sck_s ^ sck_q_r;
	assign s_lead = s_edge & (sck_q_r == cpol);
	assign s_trail = s_edge & (sck_s == cpol);
	assign m_tick = (xs_r == X_MASTER) && (div_r == 8'(HALF - 1));
	assign m_lead = m_tick & (sck_gen_r == cpol);
	assign m_trail = m_tick & (sck_gen_r != cpol);

	// fault sources
	assign mf_master = en & mstr & fden & ~ss_s; // RL2 RL17
	assign s_abort = (xs_r == X_SLAVE) & ss_s; // RL16
	assign mf_slave = s_abort & slave_on; // RL2 RL10

	// starts of a transfer
	assign m_start = en & mstr & (xs_r == X_IDLE) & ~stat_r[SB_TXE] &
		~mf_master;
	assign s_start0 = slave_on & ~clock_phase & ss_fall & (xs_r == X_IDLE); // RL7
	assign s_start1 = slave_on & clock_phase & ~ss_s & s_lead &
		(xs_r == X_IDLE); // RL8

	// deselected slave sees no edges
	assign lead_e = (m_lead) | ((xs_r == X_SLAVE) & s_lead & ~ss_s) |
		s_start1; // RL16
	assign trail_e = (m_trail) | ((xs_r == X_SLAVE) & s_trail & ~ss_s);

	// end when clock returns to idle after the eighth bit
	assign done = trail_e & (clock_phase ? (sif.cnt == CNT_LAST) :
		(sif.cnt == CNT_FULL)); // RL7 RL8 RL13

	// shifter control
	assign sif.clr = mf_master | s_abort | ~en; // RL5 RL16
	assign sif.load = m_start | s_start0 | s_start1; // RL11
	assign sif.load_data = tx_r;
	assign sif.bit_in = mstr ? miso_s : mosi_s;
	assign sif.sample = clock_phase ? trail_e : lead_e;
	assign sif.shift = clock_phase ? ((lead_e & (sif.cnt != 4'h0)) |
		(trail_e & (sif.cnt == CNT_LAST))) : trail_e; // RL13

	// transfer state
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			xs_r <= X_IDLE;
		end else if (clk_en) begin
			case (xs_r)
				X_IDLE: begin
					if (m_start) begin
						xs_r <= X_MASTER;
					end else if (s_start0 || s_start1) begin
						xs_r <= X_SLAVE;
					end
				end
				X_MASTER: begin
					if (mf_master || !en || !mstr || done) begin
						xs_r <= X_IDLE; // RL5
					end
				end
				X_SLAVE: begin
					if (s_abort || !slave_on || done) begin
						xs_r <= X_IDLE;
					end
				end
				default: begin
					xs_r <= X_IDLE;
				end
			endcase
		end
	end

	// master clock generator, idles at the polarity level
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_r <= 8'h00;
			sck_gen_r <= 1'b0;
		end else if (clk_en) begin
			if (xs_r != X_MASTER || mf_master) begin
				div_r <= 8'h00;
				sck_gen_r <= cpol;
			end else if (m_tick) begin
				div_r <= 8'h00;
				sck_gen_r <= ~sck_gen_r;
			end else begin
				div_r <= div_r + 8'h01;
			end
		end
	end

	// previous pin levels for edge detection, and done delayed one cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sck_q_r <= 1'b0;
			ss_q_r <= 1'b1;
			done_r <= 1'b0;
		end else if (clk_en) begin
			sck_q_r <= sck_s;
			ss_q_r <= ss_s;
			done_r <= done;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// software registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= CTRL_RST;
		end else if (clk_en) begin
			if (wr_ok && avs_address == ADR_CTRL) begin
				ctrl_r <= avs_writedata[5:0];
			end
			if (mf_master) begin
				ctrl_r[CB_EN] <= 1'b0; // RL5 RL9
			end
		end
	end

	// mask, port direction and port data latches
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mask_r <= MASK_RST;
			pdir_r <= PDIR_RST; // RL6
			pdat_r <= PDAT_RST;
		end else if (clk_en) begin
			if (wr_ok && avs_address == ADR_MASK) begin
				mask_r <= avs_writedata[3:0];
			end
			if (wr_ok && avs_address == ADR_PDIR) begin
				pdir_r <= avs_writedata[3:0];
			end
			if (wr_ok && avs_address == ADR_PDAT) begin
				pdat_r <= avs_writedata[3:0];
			end
		end
	end

	// transmit byte and received byte
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_r <= BYTE_RST;
			rx_r <= BYTE_RST;
		end else if (clk_en) begin
			if (wr_ok && avs_address == ADR_DATA) begin
				tx_r <= avs_writedata[7:0];
			end
			if (done_r && !stat_r[SB_RXF]) begin
				rx_r <= sif.data;
			end
		end
	end

	// status events; set wins, a read clears only the flags it returned
	always_comb begin
		stat_set = 4'h0;
		stat_set[SB_RXF] = done_r;
		stat_set[SB_OVR] = done_r & stat_r[SB_RXF];
		stat_set[SB_MODE_FAULT_FLAG] = fden & (mf_master | mf_slave); // RL3 RL15
		stat_set[SB_TXE] = sif.load | mf_master; // RL5
		stat_clr = 4'h0;
		stat_clr[SB_RXF] = rd_stat & rdata_r[SB_RXF];
		stat_clr[SB_OVR] = rd_stat & rdata_r[SB_OVR];
		stat_clr[SB_MODE_FAULT_FLAG] = rd_stat & rdata_r[SB_MODE_FAULT_FLAG];
		stat_clr[SB_TXE] = wr_ok & (avs_address == ADR_DATA);
	end

	// status register
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			stat_r <= STAT_RST;
		end else if (clk_en) begin
			stat_r <= (stat_r & ~stat_clr) | stat_set; // RL3
		end
	end

	// one interrupt line shared by receive, error and transmit-empty flags
	assign irq = |(stat_r & mask_r & {1'b1, error_interrupt_enable, error_interrupt_enable, error_interrupt_enable}); // RL4

	////////////////////////////////////////////////////////////////////////
	// pin direction and drive
	always_comb begin
		oe_nxt = pdir_r;
		drv_nxt = pdat_r;
		if (en) begin
			oe_nxt[PB_SCK] = mstr; // RL1 RL12
			oe_nxt[PB_MOSI] = mstr; // RL1 RL12
			oe_nxt[PB_MISO] = ~mstr & ~ss_s; // RL1 RL16
			drv_nxt[PB_SCK] = sck_gen_r;
			drv_nxt[PB_MOSI] = sif.bit_out;
			drv_nxt[PB_MISO] = sif.bit_out; // RL11
			if (!mstr || fden) begin
				oe_nxt[PB_SEL] = 1'b0; // RL15 RL17
			end
		end
		if (mf_master) begin
			oe_nxt = pdir_r; // RL5
			drv_nxt = pdat_r;
		end
	end

	// pin outputs come from flops
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			oe_r <= 4'h0;
			drv_r <= 4'h0;
		end else if (clk_en) begin
			oe_r <= oe_nxt;
			drv_r <= drv_nxt;
		end
	end

	assign serial_clock_oe = oe_r[PB_SCK];
	assign serial_clock_drv = drv_r[PB_SCK];
	assign mosi_oe = oe_r[PB_MOSI];
	assign mosi_drv = drv_r[PB_MOSI];
	assign miso_oe = oe_r[PB_MISO];
	assign miso_drv = drv_r[PB_MISO];
	assign select_oe = oe_r[PB_SEL];
	assign select_drv = drv_r[PB_SEL];

endmodule : smf_top

// ===== tb/smf_monitor.sv
// checker: pin direction, bus timing and clock pacing of smf_top
`timescale 1ns/1ns
module smf_monitor #(
	parameter int HALF = 4 // master clock half period
) (
	input wire logic sys_clk, // clock
	input wire logic rst_n, // reset, active low
	input wire logic clk_en, // clock enable
	input wire logic [2:0] avs_address, // word address
	input wire logic avs_read, // read
	input wire logic avs_write, // write
	input wire logic [31:0] avs_writedata, // write data
	input wire logic [3:0] avs_byteenable, // byte lanes
	input wire logic [31:0] avs_readdata, // read data
	input wire logic avs_waitrequest, // stall
	input wire logic serial_clock_drv, // clock value
	input wire logic serial_clock_oe, // clock enable out
	input wire logic mosi_oe, // master-out enable
	input wire logic miso_oe, // master-in enable
	input wire logic select_pin, // select level
	input wire logic select_oe // select enable
);
	import smf_pkg::*;
	logic [5:0] ctl_r;
	logic [3:0] dir_r;
	logic [7:0] run_r;
	logic sck_q_r;
	logic acc, m_ok, s_ok, off;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////////
	// shadow of control and port direction from accepted writes
	assign acc = avs_write && !avs_waitrequest && avs_byteenable[0] && clk_en;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl_r <= CTRL_RST;
			dir_r <= PDIR_RST;
		end else if (acc && avs_address == ADR_CTRL) begin
			ctl_r <= avs_writedata[5:0];
		end else if (acc && avs_address == ADR_PDIR) begin
			dir_r <= avs_writedata[3:0];
		end
	end
	assign m_ok = ctl_r[CB_EN] && ctl_r[CB_MSTR] && !ctl_r[CB_FDEN];
	assign s_ok = ctl_r[CB_EN] && !ctl_r[CB_MSTR];
	assign off = !ctl_r[CB_EN];
	// cycles the clock drive has held its level
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			run_r <= 8'h00;
			sck_q_r <= 1'b0;
		end else begin
			sck_q_r <= serial_clock_drv;
			run_r <= (serial_clock_drv != sck_q_r) ? 8'h01 :
				run_r + {7'h00, run_r != 8'hff};
		end
	end
	////////////////////////////////////////////////////////////////////////
	AST_MSTR_PINS: assert property (m_ok ##1 m_ok |->
		serial_clock_oe && mosi_oe && !miso_oe) else $error("master pins");
	AST_MSTR_SEL_GPIO: assert property (m_ok ##1 m_ok |->
		select_oe == $past(dir_r[3])) else $error("master select port");
	AST_SLV_PINS: assert property (s_ok ##1 s_ok |->
		!serial_clock_oe && !mosi_oe && !select_oe) else $error("slave pins");
	AST_SLV_FLOAT: assert property ((s_ok && select_pin) [*5] |->
		!miso_oe) else $error("deselected slave drives");
	AST_OFF_PORT: assert property (off ##1 off |->
		{select_oe, miso_oe, mosi_oe, serial_clock_oe} == $past(dir_r))
		else $error("disabled pins not port owned");
	AST_SCK_HALF: assert property (m_ok ##1 m_ok ##1
		(m_ok && serial_clock_drv != sck_q_r) |-> run_r >= HALF)
		else $error("clock half period short");
	AST_WAIT_ONE: assert property ($rose(avs_read) && clk_en |->
		avs_waitrequest ##1 !avs_waitrequest) else $error("read wait");
	AST_RDATA_HOLD: assert property (!avs_read |=> $stable(avs_readdata))
		else $error("read data moved");
	AST_RDATA_UPPER: assert property (avs_read && !avs_waitrequest |->
		avs_readdata[31:8] == 24'h000000) else $error("upper bits set");
endmodule : smf_monitor

bind smf_top smf_monitor #(.HALF(HALF)) u_mon (.sys_clk, .rst_n, .clk_en,
	.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
	.avs_readdata, .avs_waitrequest, .serial_clock_drv, .serial_clock_oe,
	.mosi_oe, .miso_oe, .select_pin, .select_oe);

// ===== tb/smf_far.sv
// far-side model: serial master or slave on the link pins
`timescale 1ns/1ns
module smf_far (
	input wire logic sck_in, // clock line
	input wire logic mosi_in, // master-out line
	input wire logic miso_in, // master-in line
	output logic sck_out, // clock when master
	output logic mosi_out, // data when master
	output logic miso_out, // data when slave
	output logic sel_n_out // select, active low
);
	logic slv_on = 1'b0;
	logic clock_phase = 1'b0;
	logic first_r = 1'b0;
	logic [7:0] s_tx = 8'h00;
	logic [7:0] s_rx = 8'h00;
	logic [7:0] m_rx = 8'h00;
	initial begin
		sck_out = 1'b0;
		mosi_out = 1'b0;
		miso_out = 1'b0;
		sel_n_out = 1'b1;
	end
	////////////////////////////////////////////////////////////////////////
	// slave role: leading edge samples or shifts out per phase
	always @(posedge sck_in) begin
		if (slv_on && !clock_phase) begin
			s_rx = {s_rx[6:0], mosi_in};
		end else if (slv_on) begin
			miso_out = s_tx[7];
			s_tx = {s_tx[6:0], 1'b0};
		end
	end
	// slave role: trailing edge
	always @(negedge sck_in) begin
		if (slv_on && !clock_phase) begin
			s_tx = {s_tx[6:0], 1'b0};
			miso_out = s_tx[7];
		end else if (slv_on) begin
			s_rx = {s_rx[6:0], mosi_in};
		end
	end
	////////////////////////////////////////////////////////////////////////
	// master role: one frame of nb bits at 800 ns per bit
	task mxfer(input logic ph, input logic [7:0] d, input int nb);
		logic [7:0] md;
		md = d;
		#37;
		sel_n_out = 1'b0;
		mosi_out = md[7];
		#800;
		first_r = miso_in;
		for (int i = 0; i < nb; i++) begin
			sck_out = 1'b1;
			if (ph) begin
				mosi_out = md[7];
				md = md << 1;
			end else begin
				m_rx = {m_rx[6:0], miso_in};
			end
			#400;
			sck_out = 1'b0;
			if (ph) begin
				m_rx = {m_rx[6:0], miso_in};
			end else begin
				md = md << 1;
				mosi_out = md[7];
			end
			#400;
		end
		sel_n_out = 1'b1;
		mosi_out = ~mosi_out;
		#400;
	endtask : mxfer
endmodule : smf_far

// ===== tb/smf_tb_top.sv
// bench: register tasks, far-side model and scenario tables
`timescale 1ns/1ns
module smf_tb_top;
	import smf_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0] avs_address = 3'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'h1;
	logic [31:0] avs_readdata, q;
	logic avs_waitrequest, irq, sck_drv, sck_oe, mosi_drv, mosi_oe;
	logic miso_drv, miso_oe, sel_drv, sel_oe, sck_far, mosi_far, miso_far;
	logic sel_n_far, sck_l, mosi_l, miso_l, sel_l;
	logic [7:0] tx, rx;
	logic [7:0] exp_q[$];
	logic [7:0] cfg[6] = '{8'h11, 8'h15, 8'h11, 8'h15, 8'h01, 8'h15};
	int nbt[6] = '{8, 8, 0, 0, 0, 3};
	logic [3:0] stt[6] = '{4'h9, 4'h9, 4'hc, 4'h0, 4'h8, 4'hc};
	int miscompares = 0;
	int tests_run = 0;
	int seed = 62;
	always #50 sys_clk = ~sys_clk;
	// line levels from both ends; data lags clock to give hold time
	assign sck_l = sck_oe ? sck_drv : sck_far;
	assign #5 mosi_l = mosi_oe ? mosi_drv : mosi_far;
	assign #5 miso_l = miso_oe ? miso_drv : miso_far;
	assign sel_l = sel_oe ? sel_drv : sel_n_far;
	smf_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(1'b1),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq(irq),
		.serial_clock_pin(sck_l), .serial_clock_drv(sck_drv),
		.serial_clock_oe(sck_oe), .mosi_pin(mosi_l), .mosi_drv(mosi_drv),
		.mosi_oe(mosi_oe), .miso_pin(miso_l), .miso_drv(miso_drv),
		.miso_oe(miso_oe), .select_pin(sel_l), .select_drv(sel_drv),
		.select_oe(sel_oe));
	smf_far u_far (.sck_in(sck_l), .mosi_in(mosi_l), .miso_in(miso_l),
		.sck_out(sck_far), .mosi_out(mosi_far), .miso_out(miso_far),
		.sel_n_out(sel_n_far));
	////////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task stop_test;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : stop_test
	// one avalon transfer; read data left in q
	task bus(input logic wr, input logic [2:0] a, input logic [7:0] d);
		int n;
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_write <= wr;
		avs_read <= !wr;
		n = 0;
		@(negedge sys_clk);
		while (avs_waitrequest !== 1'b0 && n < 20) begin
			@(negedge sys_clk);
			n++;
		end
		if (n >= 20) begin
			miscompares++;
			stop_test();
		end
		@(posedge sys_clk);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	task rdc(input logic [2:0] a, input logic [31:0] e);
		bus(1'b0, a, 8'h00);
		chk(q, e);
	endtask : rdc
	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		rdc(ADR_CTRL, 32'h0);
		rdc(ADR_STAT, 32'h8);
		rdc(ADR_MASK, 32'h0);
		bus(1'b1, 3'h6, 8'hff);
		rdc(3'h6, 32'h0);
		avs_byteenable <= 4'he;
		bus(1'b1, ADR_MASK, 8'h0f);
		avs_byteenable <= 4'h1;
		rdc(ADR_MASK, 32'h0);
		bus(1'b1, ADR_PDAT, 8'h0a);
		bus(1'b1, ADR_PDIR, 8'h0f);
		rdc(ADR_PDAT, 32'ha);
		chk({24'h0, sel_oe, miso_oe, mosi_oe, sck_oe, sel_drv, miso_drv,
			mosi_drv, sck_drv}, 32'hfa);
		bus(1'b1, ADR_PDIR, 8'h00);
		// design as master against the far slave, both phases
		for (int ph = 0; ph < 2; ph++) begin
			tx = 8'($random(seed));
			rx = 8'($random(seed));
			u_far.clock_phase = ph[0];
			u_far.s_tx = rx;
			u_far.miso_out = rx[7];
			u_far.slv_on = 1'b1;
			bus(1'b1, ADR_CTRL, 8'h03 | (8'(ph) << CB_CLOCK_PHASE));
			repeat (2) @(posedge sys_clk);
			chk({29'h0, sck_oe, mosi_oe, miso_oe}, 32'h6);
			exp_q.push_back(rx);
			bus(1'b1, ADR_DATA, tx);
			q = 32'h0;
			for (int n = 0; n < 60 && q[SB_RXF] !== 1'b1; n++) begin
				bus(1'b0, ADR_STAT, 8'h00);
			end
			chk(q, 32'h9);
			rdc(ADR_DATA, {24'h0, exp_q.pop_front()});
			chk({24'h0, u_far.s_rx}, {24'h0, tx});
		end
		u_far.slv_on = 1'b0;
		// master fault from a second master pulling select low
		bus(1'b1, ADR_MASK, 8'h04);
		bus(1'b1, ADR_CTRL, 8'h33);
		#37 u_far.sel_n_out = 1'b0;
		repeat (8) @(posedge sys_clk);
		chk({31'h0, irq}, 32'h1);
		chk({29'h0, sck_oe, mosi_oe, miso_oe}, 32'h0);
		bus(1'b0, ADR_PDAT, 8'h00);
		chk(q & 32'h8, 32'h0);
		rdc(ADR_CTRL, 32'h32);
		bus(1'b1, ADR_CTRL, 8'h23);
		rdc(ADR_STAT, 32'hc);
		@(negedge sys_clk);
		chk({31'h0, irq}, 32'h0);
		repeat (6) @(posedge sys_clk);
		rdc(ADR_STAT, 32'h8);
		rdc(ADR_CTRL, 32'h23);
		@(negedge sys_clk);
		u_far.sel_n_out = 1'b1;
		bus(1'b1, ADR_MASK, 8'h00);
		// design as slave: full bytes, bare selects and an abort
		for (int i = 0; i < 6; i++) begin
			tx = 8'($random(seed));
			rx = 8'($random(seed));
			bus(1'b1, ADR_CTRL, cfg[i]);
			bus(1'b1, ADR_DATA, tx);
			u_far.miso_out = ~tx[7];
			u_far.mxfer(cfg[i][CB_CLOCK_PHASE], rx, nbt[i]);
			if (nbt[i] == 8) begin
				if (!cfg[i][CB_CLOCK_PHASE]) begin
					chk({31'h0, u_far.first_r}, {31'h0, tx[7]});
				end
				chk({24'h0, u_far.m_rx}, {24'h0, tx});
				exp_q.push_back(rx);
				rdc(ADR_DATA, {24'h0, exp_q.pop_front()});
			end
			repeat (4) @(posedge sys_clk);
			chk({31'h0, irq}, 32'h0);
			rdc(ADR_STAT, {28'h0, stt[i]});
		end
		stop_test();
	end
endmodule : smf_tb_top
